//--- hw/orb_fifo_pkg.sv
package orb_fifo_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MGMT_RX = 8'h38;
  localparam logic [7:0] OFS_CMD_TX = 8'h3c;
  localparam logic [7:0] OFS_CMD_RX = 8'h40;
  localparam logic [7:0] OFS_ORB_CTRL = 8'h44;
  // Reset words
  localparam logic [31:0] RST_MGMT_RX = 32'h10000000;
  localparam logic [31:0] RST_CMD_TX = 32'h1000000f;
  localparam logic [31:0] RST_CMD_RX = 32'h1000004b;
  localparam logic [8:0] CMD_TX_DEPTH_RST = 9'h00f;
  localparam logic [8:0] CMD_RX_DEPTH_RST = 9'h04b;
  localparam logic [7:0] ORB_LEN_RST = 8'h08;
  // Field positions as vector indices; documented bit n sits at index 31-n
  localparam int BIT_FULL = 31;
  localparam int BIT_AFULL = 30;
  localparam int BIT_AEMPTY = 29;
  localparam int BIT_EMPTY = 28;
  localparam int BIT_PKT_AV = 26;
  localparam int CNT_LSB = 16;
  localparam int BIT_FIRST = 15;
  localparam int BIT_FLUSH = 12;
  localparam int SIZE_LSB = 0;
  localparam int ORB_LEN_LSB = 16;
  // Channels
  localparam int NUM_CH = 3;
  localparam int CH_MGMT = 0;
  localparam int CH_TX = 1;
  localparam int CH_RX = 2;
  // Quadlets in one transmit command packet
  localparam logic [8:0] TX_PKT_QUADS = 9'h003;
endpackage : orb_fifo_pkg

//--- hw/orb_fifo_status_regs.sv
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Management FIFO full flag; pushes ignored
// - Management almost-full when one slot left
// - Management almost-empty when one quadlet held
// - Management empty flag; forced on bus reset
// - Management quadlet count field, cleared by reset
// - Management first-quadlet indicator on pop
// - Management flush bit empties, self-clears
// - Management register reset word, bus reset clears
// - Transmit queue full flag; pushes ignored
// - Transmit almost-full zero after three quadlets
// - Transmit almost-empty with exactly one quadlet
// - Transmit empty flag, set on bus reset
// - Transmit packet-available flag for three quadlets
// - Transmit flush bit empties, self-clears
// - Transmit size field, survives bus reset
// - Command receive full flag; pushes discarded
// - Command receive almost-full with one slot
// - Command receive almost-empty and empty flags
// - Command receive quadlet count field
// - Command receive first-quadlet indicator on pop
// - Command receive flush bit empties, self-clears
// - Command ORB length setting, default eight
module orb_fifo_status_regs #(
  parameter logic [8:0] MGMT_DEPTH = 9'h020,
  parameter logic [8:0] CMD_TX_CAP = 9'h003
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_bus_reset,
  // Avalon-MM slave
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // FIFO strobes, index 0 mgmt, 1 transmit, 2 command receive
  input wire logic [2:0] i_push,
  input wire logic [2:0] i_pop,
  input wire logic [2:0] i_pop_first,
  output logic [2:0] o_push_accept,
  output logic [2:0] o_pop_accept,
  output logic [2:0] o_flush,
  // Configuration to the fetch agents
  output logic [8:0] o_cmd_rx_depth,
  output logic [7:0] o_command_orb_length
);

  logic [8:0] cnt_q [orb_fifo_pkg::NUM_CH];
  logic [8:0] cnt_d [orb_fifo_pkg::NUM_CH];
  logic [8:0] cap [orb_fifo_pkg::NUM_CH];
  logic [31:0] flag_w [orb_fifo_pkg::NUM_CH];
  logic [2:0] full, afull, aempty, empty;
  logic [2:0] flush_q, first_q, flush_wr;
  logic [8:0] cmd_tx_depth_q, cmd_rx_depth_q;
  logic [7:0] command_orb_length_q;
  logic pkt_av_q, ack_q;
  logic [31:0] rdata_q;

  // Bus decode; one wait state lets read data come from a flop
  wire req = i_read | i_write;
  wire commit = req & ack_q;
  wire wr_commit = commit & i_write;
  wire sel_mgmt = (i_address == orb_fifo_pkg::OFS_MGMT_RX);
  wire sel_tx = (i_address == orb_fifo_pkg::OFS_CMD_TX);
  wire sel_rx = (i_address == orb_fifo_pkg::OFS_CMD_RX);
  wire sel_orb = (i_address == orb_fifo_pkg::OFS_ORB_CTRL);
  wire [31:0] be_mask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                         {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
  wire flush_lane = i_byteenable[orb_fifo_pkg::BIT_FLUSH / 8];
  wire flush_bit = i_writedata[orb_fifo_pkg::BIT_FLUSH] & flush_lane;
  assign flush_wr[orb_fifo_pkg::CH_MGMT] = wr_commit & sel_mgmt & flush_bit;
  assign flush_wr[orb_fifo_pkg::CH_TX] = wr_commit & sel_tx & flush_bit;
  assign flush_wr[orb_fifo_pkg::CH_RX] = wr_commit & sel_rx & flush_bit;
  assign o_waitrequest = req & ~ack_q;

  // Capacities; receive size is trusted to cover the ORB length
  assign cap[orb_fifo_pkg::CH_MGMT] = MGMT_DEPTH;
  assign cap[orb_fifo_pkg::CH_TX] = CMD_TX_CAP;
  assign cap[orb_fifo_pkg::CH_RX] = cmd_rx_depth_q;

  // Per-FIFO occupancy, flags, first-quadlet and flush
  genvar g;
  for (g = 0; g < orb_fifo_pkg::NUM_CH; g++) begin : g_ch
    assign full[g] = (cnt_q[g] == cap[g]);
    assign afull[g] = (9'(cnt_q[g] + 9'h001) == cap[g]);
    assign aempty[g] = (cnt_q[g] == 9'h001);
    assign empty[g] = (cnt_q[g] == 9'h000);
    // Pushes while full, or during a flush, are dropped
    assign o_push_accept[g] = i_push[g] & ~full[g] & ~flush_q[g];
    assign o_pop_accept[g] = i_pop[g] & ~empty[g] & ~flush_q[g];
    assign cnt_d[g] = flush_q[g] ? 9'h000 :
                      9'(cnt_q[g] + {8'h00, o_push_accept[g]} - {8'h00, o_pop_accept[g]});
    assign flag_w[g] = (32'(full[g]) << orb_fifo_pkg::BIT_FULL)
                     | (32'(afull[g]) << orb_fifo_pkg::BIT_AFULL)
                     | (32'(aempty[g]) << orb_fifo_pkg::BIT_AEMPTY)
                     | (32'(empty[g]) << orb_fifo_pkg::BIT_EMPTY)
                     | (32'(flush_q[g]) << orb_fifo_pkg::BIT_FLUSH);
    // Count, cleared by either reset and one cycle into a flush
    always_ff @(posedge i_sys_clk) begin
      if (i_rst | i_bus_reset) begin
        cnt_q[g] <= 9'h000;
      end else begin
        cnt_q[g] <= cnt_d[g];
      end
    end
    // First-quadlet marker follows the most recent accepted pop
    always_ff @(posedge i_sys_clk) begin
      if (i_rst | i_bus_reset | flush_q[g]) begin
        first_q[g] <= 1'b0;
      end else if (o_pop_accept[g]) begin
        first_q[g] <= i_pop_first[g];
      end
    end
    // Flush holds one cycle while the count empties, then drops
    always_ff @(posedge i_sys_clk) begin
      if (i_rst | i_bus_reset) begin
        flush_q[g] <= 1'b0;
      end else begin
        flush_q[g] <= flush_wr[g] & ~flush_q[g];
      end
    end
  end
  assign o_flush = flush_q;

  // Packet room is reported only once draining frees it, so reset reads zero
  wire [8:0] tx_room_d = 9'(CMD_TX_CAP - cnt_d[orb_fifo_pkg::CH_TX]);
  always_ff @(posedge i_sys_clk) begin
    if (i_rst | i_bus_reset) begin
      pkt_av_q <= 1'b0;
    end else if (tx_room_d < orb_fifo_pkg::TX_PKT_QUADS) begin
      pkt_av_q <= 1'b0;
    end else if (o_pop_accept[orb_fifo_pkg::CH_TX]) begin
      pkt_av_q <= 1'b1;
    end
  end

  // Writable fields merged per byte lane; all else but the flush bit ignored on write
  wire [8:0] tx_depth_d = (cmd_tx_depth_q & ~be_mask[8:0]) | (i_writedata[8:0] & be_mask[8:0]);
  wire [8:0] rx_depth_d = (cmd_rx_depth_q & ~be_mask[8:0]) | (i_writedata[8:0] & be_mask[8:0]);
  wire [7:0] orb_mask = be_mask[orb_fifo_pkg::ORB_LEN_LSB +: 8];
  wire [7:0] orb_len_d = (command_orb_length_q & ~orb_mask)
                       | (i_writedata[orb_fifo_pkg::ORB_LEN_LSB +: 8] & orb_mask);

  // Size fields only see the hard reset, not bus reset
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cmd_tx_depth_q <= orb_fifo_pkg::CMD_TX_DEPTH_RST;
      cmd_rx_depth_q <= orb_fifo_pkg::CMD_RX_DEPTH_RST;
      command_orb_length_q <= orb_fifo_pkg::ORB_LEN_RST;
    end else if (wr_commit) begin
      cmd_tx_depth_q <= sel_tx ? tx_depth_d : cmd_tx_depth_q;
      cmd_rx_depth_q <= sel_rx ? rx_depth_d : cmd_rx_depth_q;
      command_orb_length_q <= sel_orb ? orb_len_d : command_orb_length_q;
    end
  end
  assign o_cmd_rx_depth = cmd_rx_depth_q;
  assign o_command_orb_length = command_orb_length_q;

  // Read words; reserved bits stay zero as in the reset words
  wire [31:0] mgmt_stat = flag_w[orb_fifo_pkg::CH_MGMT]
      | (32'(cnt_q[orb_fifo_pkg::CH_MGMT]) << orb_fifo_pkg::CNT_LSB)
      | (32'(first_q[orb_fifo_pkg::CH_MGMT]) << orb_fifo_pkg::BIT_FIRST);
  wire [31:0] tx_stat = flag_w[orb_fifo_pkg::CH_TX]
      | (32'(pkt_av_q) << orb_fifo_pkg::BIT_PKT_AV)
      | (32'(cmd_tx_depth_q) << orb_fifo_pkg::SIZE_LSB);
  wire [31:0] rx_stat = flag_w[orb_fifo_pkg::CH_RX]
      | (32'(cnt_q[orb_fifo_pkg::CH_RX]) << orb_fifo_pkg::CNT_LSB)
      | (32'(first_q[orb_fifo_pkg::CH_RX]) << orb_fifo_pkg::BIT_FIRST)
      | (32'(cmd_rx_depth_q) << orb_fifo_pkg::SIZE_LSB);
  wire [31:0] orb_word = 32'(command_orb_length_q) << orb_fifo_pkg::ORB_LEN_LSB;
  wire [31:0] rd_mux = sel_mgmt ? mgmt_stat :
                       sel_tx ? tx_stat :
                       sel_rx ? rx_stat :
                       sel_orb ? orb_word : 32'h00000000;

  // Handshake and read data capture in the wait cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      rdata_q <= (i_read & ~ack_q) ? rd_mux : rdata_q;
    end
  end
  assign o_readdata = rdata_q;

  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst || i_bus_reset);

  sequence flush_start_s;
    flush_wr[orb_fifo_pkg::CH_MGMT] && !flush_q[orb_fifo_pkg::CH_MGMT];
  endsequence
  sequence flush_done_s;
    flush_q[orb_fifo_pkg::CH_MGMT] ##1 (!flush_q[orb_fifo_pkg::CH_MGMT] && empty[orb_fifo_pkg::CH_MGMT]);
  endsequence

  mgmt_full_drop_a: assert property (
    full[0] && i_push[0] && !o_pop_accept[0] && !flush_q[0] |=> cnt_q[0] == $past(cnt_q[0]))
    else $error("push into full management fifo changed count");
  mgmt_afull_a: assert property (
    mgmt_stat[orb_fifo_pkg::BIT_AFULL] == (9'(MGMT_DEPTH - cnt_q[0]) == 9'h001))
    else $error("management almost-full wrong");
  mgmt_aempty_a: assert property (
    empty[0] && o_push_accept[0] && !i_pop[0] |=> mgmt_stat[orb_fifo_pkg::BIT_AEMPTY] && !empty[0])
    else $error("management almost-empty not set after one push");
  bus_reset_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_bus_reset |=> mgmt_stat[orb_fifo_pkg::BIT_EMPTY] && cnt_q[0] == 9'h000 && !first_q[0])
    else $error("bus reset did not clear management status");
  mgmt_first_a: assert property (
    o_pop_accept[0] && i_pop_first[0] |=> mgmt_stat[orb_fifo_pkg::BIT_FIRST])
    else $error("first-quadlet indicator not set");
  mgmt_flush_a: assert property (
    flush_start_s |=> flush_done_s)
    else $error("management flush did not empty and self-clear");
  tx_afull_three_a: assert property (
    cnt_q[1] == orb_fifo_pkg::TX_PKT_QUADS && CMD_TX_CAP == orb_fifo_pkg::TX_PKT_QUADS
    |-> !tx_stat[orb_fifo_pkg::BIT_AFULL] && tx_stat[orb_fifo_pkg::BIT_FULL])
    else $error("transmit flags wrong at three quadlets");
  tx_depth_keep_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_bus_reset && !wr_commit |=> cmd_tx_depth_q == $past(cmd_tx_depth_q))
    else $error("transmit size changed on bus reset");
  rx_full_drop_a: assert property (
    full[2] && i_push[2] |-> !o_push_accept[2])
    else $error("push accepted into full command receive fifo");
  bus_answer_a: assert property (
    req |-> ##[0:1] !o_waitrequest)
    else $error("bus request not answered within one wait state");

  // Flush sequences for the two command FIFOs
  sequence tx_flush_start_s;
    flush_wr[1] && !flush_q[1];
  endsequence
  sequence tx_flush_done_s;
    flush_q[1] ##1 (!flush_q[1] && empty[1]);
  endsequence
  sequence rx_flush_start_s;
    flush_wr[2] && !flush_q[2];
  endsequence
  sequence rx_flush_done_s;
    flush_q[2] ##1 (!flush_q[2] && empty[2]);
  endsequence

  // Management status levels against the count
  mgmt_full_flag_a: assert property (
    cnt_q[0] == MGMT_DEPTH |-> mgmt_stat[orb_fifo_pkg::BIT_FULL])
    else $error("management full flag not set at capacity");
  mgmt_bound_a: assert property (
    cnt_q[0] <= MGMT_DEPTH)
    else $error("management count above capacity");
  mgmt_aempty_level_a: assert property (
    mgmt_stat[orb_fifo_pkg::BIT_AEMPTY] == (cnt_q[0] == 9'h001))
    else $error("management almost-empty level wrong");
  mgmt_empty_level_a: assert property (
    mgmt_stat[orb_fifo_pkg::BIT_EMPTY] == (cnt_q[0] == 9'h000))
    else $error("management empty level wrong");
  mgmt_count_up_a: assert property (
    o_push_accept[0] && !o_pop_accept[0] |=> cnt_q[0] == 9'($past(cnt_q[0]) + 9'h001))
    else $error("management count did not step up");
  mgmt_count_down_a: assert property (
    o_pop_accept[0] && !o_push_accept[0] |=> cnt_q[0] == 9'($past(cnt_q[0]) - 9'h001))
    else $error("management count did not step down");
  mgmt_count_field_a: assert property (
    mgmt_stat[orb_fifo_pkg::CNT_LSB +: 9] == cnt_q[0])
    else $error("management count field wrong");
  mgmt_first_clear_a: assert property (
    o_pop_accept[0] && !i_pop_first[0] |=> !mgmt_stat[orb_fifo_pkg::BIT_FIRST])
    else $error("management first-quadlet indicator not cleared");
  mgmt_flush_block_a: assert property (
    flush_q[0] |-> !o_push_accept[0] && !o_pop_accept[0])
    else $error("strobe accepted during management flush");
  mgmt_reserved_a: assert property (
    mgmt_stat[orb_fifo_pkg::SIZE_LSB +: 9] == 9'h000 && !mgmt_stat[orb_fifo_pkg::BIT_PKT_AV])
    else $error("management reserved bits not zero");

  // Transmit queue flags and packet room
  tx_full_flag_a: assert property (
    i_push[1] && cnt_q[1] == CMD_TX_CAP |-> !o_push_accept[1] && tx_stat[orb_fifo_pkg::BIT_FULL])
    else $error("push accepted into full transmit queue");
  tx_bound_a: assert property (
    cnt_q[1] <= CMD_TX_CAP)
    else $error("transmit count above capacity");
  tx_afull_level_a: assert property (
    tx_stat[orb_fifo_pkg::BIT_AFULL] == (9'(CMD_TX_CAP - cnt_q[1]) == 9'h001))
    else $error("transmit almost-full level wrong");
  tx_aempty_two_a: assert property (
    cnt_q[1] == 9'h002 |-> !tx_stat[orb_fifo_pkg::BIT_AEMPTY])
    else $error("transmit almost-empty set with two quadlets");
  tx_empty_level_a: assert property (
    tx_stat[orb_fifo_pkg::BIT_EMPTY] == (cnt_q[1] == 9'h000))
    else $error("transmit empty level wrong");
  tx_pkt_room_a: assert property (
    tx_stat[orb_fifo_pkg::BIT_PKT_AV] |-> 9'(CMD_TX_CAP - cnt_q[1]) >= orb_fifo_pkg::TX_PKT_QUADS)
    else $error("packet-available set without room");
  tx_pkt_set_a: assert property (
    o_pop_accept[1] && 9'(CMD_TX_CAP - cnt_d[1]) >= orb_fifo_pkg::TX_PKT_QUADS
    |=> tx_stat[orb_fifo_pkg::BIT_PKT_AV])
    else $error("packet-available not set after drain");
  tx_flush_a: assert property (
    tx_flush_start_s |=> tx_flush_done_s)
    else $error("transmit flush did not empty and self-clear");
  tx_depth_field_a: assert property (
    tx_stat[orb_fifo_pkg::SIZE_LSB +: 9] == cmd_tx_depth_q)
    else $error("transmit size field wrong");

  // Command receive flags, count and first marker
  rx_full_flag_a: assert property (
    cnt_q[2] == cmd_rx_depth_q |-> rx_stat[orb_fifo_pkg::BIT_FULL])
    else $error("command receive full flag not set");
  rx_afull_level_a: assert property (
    rx_stat[orb_fifo_pkg::BIT_AFULL] == (9'(cmd_rx_depth_q - cnt_q[2]) == 9'h001))
    else $error("command receive almost-full level wrong");
  rx_empty_level_a: assert property (
    rx_stat[orb_fifo_pkg::BIT_EMPTY] == (cnt_q[2] == 9'h000)
    && rx_stat[orb_fifo_pkg::BIT_AEMPTY] == (cnt_q[2] == 9'h001))
    else $error("command receive empty levels wrong");
  rx_count_up_a: assert property (
    o_push_accept[2] && !o_pop_accept[2] |=> cnt_q[2] == 9'($past(cnt_q[2]) + 9'h001))
    else $error("command receive count did not step up");
  rx_count_field_a: assert property (
    rx_stat[orb_fifo_pkg::CNT_LSB +: 9] == cnt_q[2])
    else $error("command receive count field wrong");
  rx_first_a: assert property (
    o_pop_accept[2] |=> rx_stat[orb_fifo_pkg::BIT_FIRST] == $past(i_pop_first[2]))
    else $error("command receive first-quadlet indicator wrong");
  rx_flush_a: assert property (
    rx_flush_start_s |=> rx_flush_done_s)
    else $error("command receive flush did not empty and self-clear");

  // Configuration survives bus reset; unmapped reads return zero
  orb_len_keep_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_bus_reset && !(wr_commit && sel_orb) |=> command_orb_length_q == $past(command_orb_length_q))
    else $error("ORB length changed on bus reset");
  unmapped_read_a: assert property (
    i_read && !ack_q && !(sel_mgmt || sel_tx || sel_rx || sel_orb) |=> o_readdata == 32'h00000000)
    else $error("unmapped read returned nonzero data");

endmodule : orb_fifo_status_regs

//--- sim/fifo_side.sv
`timescale 1ns/1ps
// Storage side of the three FIFOs: one strobe per quadlet
module fifo_side (
  // Clock
  input wire logic i_clk,
  // Answers from the block
  input wire logic [2:0] i_push_accept,
  input wire logic [2:0] i_pop_accept,
  // Strobes to the block
  output logic [2:0] o_push,
  output logic [2:0] o_pop,
  output logic [2:0] o_pop_first
);
  // First marker idles high so the block cannot lean on it outside a pop
  initial begin
    o_push = 3'h0;
    o_pop = 3'h0;
    o_pop_first = 3'h7;
  end

  // One-cycle strobe; accept is sampled at the edge that ends it
  task automatic strobe(input bit pop, input int ch, input bit first, output logic acc);
    @(posedge i_clk);
    if (pop) begin
      o_pop[ch] <= 1'b1;
      o_pop_first[ch] <= first;
    end else o_push[ch] <= 1'b1;
    @(posedge i_clk);
    acc = pop ? i_pop_accept[ch] : i_push_accept[ch];
    o_push <= 3'h0;
    o_pop <= 3'h0;
    o_pop_first <= 3'h7;
  endtask : strobe
endmodule : fifo_side

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic i_sys_clk, i_rst, i_bus_reset, i_read, i_write, o_waitrequest;
  logic [7:0] i_address, o_command_orb_length;
  logic [3:0] i_byteenable;
  logic [31:0] i_writedata, o_readdata;
  logic [2:0] i_push, i_pop, i_pop_first, o_push_accept, o_pop_accept, o_flush;
  logic [8:0] o_cmd_rx_depth;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  // Small management depth so full is reached quickly
  orb_fifo_status_regs #(.MGMT_DEPTH(9'h004), .CMD_TX_CAP(9'h003)) dut (.i_sys_clk, .i_rst, .i_bus_reset,
    .i_address, .i_read, .i_write, .i_byteenable, .i_writedata, .o_readdata, .o_waitrequest, .i_push, .i_pop,
    .i_pop_first, .o_push_accept, .o_pop_accept, .o_flush, .o_cmd_rx_depth, .o_command_orb_length);
  fifo_side side (.i_clk(i_sys_clk), .i_push_accept(o_push_accept), .i_pop_accept(o_pop_accept),
    .o_push(i_push), .o_pop(i_pop), .o_pop_first(i_pop_first));

  // Clock
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  // Hang guard, far above the roughly 150 cycles needed
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end

  task automatic results();
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp32

  // Flags: full, almost full, almost empty, empty, packet room
  function automatic logic [31:0] st(input logic [4:0] fl, input logic [8:0] cnt, input logic first,
                                     input logic [8:0] size);
    logic [31:0] w;
    w = 32'h0;
    w[orb_fifo_pkg::BIT_EMPTY +: 4] = fl[4:1];
    w[orb_fifo_pkg::BIT_PKT_AV] = fl[0];
    w[orb_fifo_pkg::CNT_LSB +: 9] = cnt;
    w[orb_fifo_pkg::BIT_FIRST] = first;
    w[orb_fifo_pkg::SIZE_LSB +: 9] = size;
    return w;
  endfunction : st

  // Avalon transfer; values read right after the edge are those sampled by it
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge i_sys_clk);
    i_address <= a;
    i_writedata <= d;
    i_byteenable <= be;
    if (wr) i_write <= 1'b1;
    else i_read <= 1'b1;
    do begin
      @(posedge i_sys_clk);
    end while (o_waitrequest !== 1'b0);
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    cmp32($sformatf("register %h", a), exp, q);
  endtask : rd

  // Write, then look at the flush pulse in the cycle after the commit
  task automatic wrf(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be, input logic [2:0] fl);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
    @(posedge i_sys_clk);
    cmp32("flush pulse", {29'h0, fl}, {29'h0, o_flush});
  endtask : wrf

  task automatic fill(input int ch, input int n, input bit pop, input bit first, input logic exp);
    logic acc;
    repeat (n) begin
      side.strobe(pop, ch, first, acc);
      cmp32("accept", {31'h0, exp}, {31'h0, acc});
    end
  endtask : fill

  task automatic t_reset();
    rd(8'h38, orb_fifo_pkg::RST_MGMT_RX);
    rd(8'h3c, orb_fifo_pkg::RST_CMD_TX);
    rd(8'h40, orb_fifo_pkg::RST_CMD_RX);
    rd(8'h44, 32'h00080000);
    rd(8'h48, 32'h0);
  endtask : t_reset

  task automatic t_mgmt();
    fill(0, 1, 0, 0, 1'b1);
    rd(8'h38, st(5'b00100, 9'h1, 0, 9'h0));
    fill(0, 2, 0, 0, 1'b1);
    rd(8'h38, st(5'b01000, 9'h3, 0, 9'h0));
    fill(0, 1, 0, 0, 1'b1);
    fill(0, 1, 0, 0, 1'b0);
    rd(8'h38, st(5'b10000, 9'h4, 0, 9'h0));
    fill(0, 1, 1, 1, 1'b1);
    rd(8'h38, st(5'b01000, 9'h3, 1, 9'h0));
    wrf(8'h38, 32'hffffffff, 4'hf, 3'b001);
    rd(8'h38, orb_fifo_pkg::RST_MGMT_RX);
  endtask : t_mgmt

  task automatic t_tx();
    wrf(8'h3c, 32'hffffffff, 4'hf, 3'b010);
    rd(8'h3c, st(5'b00010, 9'h0, 0, 9'h1ff));
    fill(1, 1, 0, 0, 1'b1);
    rd(8'h3c, st(5'b00100, 9'h0, 0, 9'h1ff));
    fill(1, 1, 0, 0, 1'b1);
    rd(8'h3c, st(5'b01000, 9'h0, 0, 9'h1ff));
    fill(1, 1, 0, 0, 1'b1);
    fill(1, 1, 0, 0, 1'b0);
    rd(8'h3c, st(5'b10000, 9'h0, 0, 9'h1ff));
    fill(1, 3, 1, 0, 1'b1);
    rd(8'h3c, st(5'b00011, 9'h0, 0, 9'h1ff));
  endtask : t_tx

  task automatic t_rx();
    wrf(8'h40, 32'h00000008, 4'h3, 3'b000);
    cmp32("rx depth", 32'h8, {23'h0, o_cmd_rx_depth});
    wrf(8'h44, 32'h00040000, 4'h4, 3'b000);
    cmp32("orb length", 32'h4, {24'h0, o_command_orb_length});
    fill(2, 7, 0, 0, 1'b1);
    rd(8'h40, st(5'b01000, 9'h7, 0, 9'h8));
    fill(2, 1, 0, 0, 1'b1);
    fill(2, 1, 0, 0, 1'b0);
    rd(8'h40, st(5'b10000, 9'h8, 0, 9'h8));
    fill(2, 1, 1, 1, 1'b1);
    rd(8'h40, st(5'b01000, 9'h7, 1, 9'h8));
    wrf(8'h40, 32'h00001000, 4'h2, 3'b100);
    rd(8'h40, st(5'b00010, 9'h0, 0, 9'h8));
  endtask : t_rx

  // Bus reset with data held; sizes must survive
  task automatic t_breset();
    fill(0, 2, 0, 0, 1'b1);
    fill(2, 3, 0, 0, 1'b1);
    @(posedge i_sys_clk);
    i_bus_reset <= 1'b1;
    @(posedge i_sys_clk);
    i_bus_reset <= 1'b0;
    rd(8'h38, orb_fifo_pkg::RST_MGMT_RX);
    rd(8'h3c, st(5'b00010, 9'h0, 0, 9'h1ff));
    rd(8'h40, st(5'b00010, 9'h0, 0, 9'h8));
    cmp32("orb length", 32'h4, {24'h0, o_command_orb_length});
  endtask : t_breset

  // Main sequence
  initial begin
    i_rst = 1'b1;
    i_bus_reset = 1'b0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_address = 8'h0;
    i_byteenable = 4'h0;
    i_writedata = 32'h0;
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_reset();
    t_mgmt();
    t_tx();
    t_rx();
    t_breset();
    results();
  end
endmodule : tb
